// ===== rtl/csq_cfg.svh
`ifndef CSQ_CFG_SVH
`define CSQ_CFG_SVH

// command codes seen on the line
`define CSQ_CMD_MATCH        8'h55
`define CSQ_CMD_SKIP         8'hCC
`define CSQ_CMD_SEARCH       8'hF0
`define CSQ_CMD_COND_SEARCH  8'hEC

// status memory locations
`define CSQ_ADDR_DEFAULT     3'h6
`define CSQ_ADDR_ACTIVE      3'h7

// unprogrammed default byte, every condition bit one
`define CSQ_COND_RESET       8'hFF

// latch clear bit in channel control byte 1
`define CSQ_LATCH_CLR_BIT    7

// identifier length and last bit index
`define CSQ_ID_BITS          64
`define CSQ_ID_LAST          6'h3F

`endif

// ===== rtl/csq_pkg.sv
package csq_pkg;

	// five condition bits in their status byte order (bit 0 = polarity)
	typedef struct packed {
		logic [2:0] unused;
		logic       channel_select_high;
		logic       channel_select_low;
		logic       source_select_high;
		logic       source_select_low;
		logic       match_polarity_bit;
	} cond_t;

	// one value per channel for each possible source
	typedef struct packed {
		logic activity;
		logic flop;
		logic pin;
	} chan_src_t;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'b000_0001,
		ST_SRCH_ID  = 7'b000_0010,
		ST_SRCH_CMP = 7'b000_0100,
		ST_SRCH_WR  = 7'b000_1000,
		ST_MATCH    = 7'b001_0000,
		ST_SELECTED = 7'b010_0000,
		ST_DROPPED  = 7'b100_0000
	} rom_state_t;

	typedef struct packed {
		rom_state_t state;
		logic [5:0] bit_idx;
		logic       loaded;
		logic       powerup_presence;
		logic       qualified;
		logic       sample;
		logic       search_bit;
		logic [7:0] rdata;
	} qual_state_t;

endpackage : csq_pkg

// ===== rtl/activity_latch_pair.sv
`timescale 1ns/1ns
`default_nettype none
`include "csq_cfg.svh"

module activity_latch_pair (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// pins and clear strobe
	input  wire logic [1:0] pin_i,
	input  wire logic       clear_i,
	// latched activity
	output logic      [1:0] latch_o
);
	import csq_pkg::*;

	typedef struct packed {
		logic       primed;
		logic [1:0] prev;
		logic [1:0] latch;
	} act_state_t;

	act_state_t r;
	act_state_t next_r;

	// first cycle only primes the edge detector, avoiding a false edge
	always_comb begin
		next_r        = r;
		next_r.primed = 1'b1;
		next_r.prev   = pin_i;
		if (clear_i) begin
			next_r.latch = 2'h0;
		end
		if (r.primed) begin
			// an edge in the clear cycle still sets the latch
			next_r.latch = next_r.latch | (pin_i ^ r.prev);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign latch_o = r.latch;

	edge_sets_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.primed && (pin_i[0] != r.prev[0]) |=> latch_o[0])
		else $error("edge on channel A did not set its latch");

endmodule : activity_latch_pair
`default_nettype wire

// ===== rtl/condition_store.sv
`timescale 1ns/1ns
`default_nettype none
`include "csq_cfg.svh"

module condition_store (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// status memory write
	input  wire logic       wr_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	// copy default into working condition
	input  wire logic       load_i,
	// stored bytes
	output logic      [7:0] default_o,
	output logic      [7:0] active_o
);
	import csq_pkg::*;

	typedef struct packed {
		logic [7:0] dflt;
		logic [7:0] active;
	} store_state_t;

	store_state_t r;
	store_state_t next_r;

	// default byte is one-time programmable: writes only clear bits
	always_comb begin
		next_r = r;
		if (load_i) begin
			next_r.active = r.dflt;
		end
		if (wr_i && addr_i == `CSQ_ADDR_DEFAULT) begin
			next_r.dflt = r.dflt & wdata_i;
		end
		if (wr_i && addr_i == `CSQ_ADDR_ACTIVE) begin
			next_r.active = wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= {`CSQ_COND_RESET, `CSQ_COND_RESET};
		end else begin
			r <= next_r;
		end
	end

	assign default_o = r.dflt;
	assign active_o  = r.active;

	active_write_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_i && addr_i == `CSQ_ADDR_ACTIVE |=> active_o == $past(wdata_i))
		else $error("active condition write not kept");

endmodule : condition_store
`default_nettype wire

// ===== rtl/conditional_search_qualifier.sv
// Summary of operation
// - conditional search runs the search steps only when the condition holds
// - five condition bits live in status location 7, readable and writable
// - power-on defaults come from location 6; unprogrammed means all ones
// - a fully resolved search leaves the device selected like a match
// - activity latch clears at power-up, sets on any pin edge
// - writing one to latch clear bit of control byte 1 clears latches
// - source is sampled when the conditional search byte completes
// - channel select: 00 none, 01 A, 10 B, 11 A or B
// - both channels selected: OR of sources compared with polarity
// - no channel: polarity zero always qualifies, polarity one never
// - source select: 00 hidden, 01 latch, 10 flop, 11 pin level
// - hidden mode answers match always, conditional search with polarity one
// - hidden mode suppresses presence after reset pulses
// - powering up hidden still gives one presence per power-up
// - leave hidden by power-on reset or match then source bit write
// - polarity zero qualifies on source zero, one on source one
// - single-channel build presents channel B sources as zero
// - first command byte after reset loads defaults into working bits
// - written conditions persist while powered
// - search step: send bit, send complement, read master bit, drop on miss
// - match compares 64 bits; mismatch waits for the next reset pulse
`timescale 1ns/1ns
`default_nettype none
`include "csq_cfg.svh"

module conditional_search_qualifier #(
	parameter bit TWO_CHANNEL = 1'b1
) (
	// clock and power-on reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	// line events from the slot decoder
	input  wire logic                  reset_pulse_i,
	input  wire logic                  cmd_valid_i,
	input  wire logic [7:0]            cmd_byte_i,
	input  wire logic                  slot_wr_i,
	input  wire logic                  slot_bit_i,
	input  wire logic                  slot_rd_i,
	// identifier
	input  wire logic [63:0]           rom_id_i,
	// status memory access
	input  wire logic                  stat_wr_i,
	input  wire logic [2:0]            stat_addr_i,
	input  wire logic [7:0]            stat_wdata_i,
	output logic      [7:0]            stat_rdata_o,
	// channel control byte 1 write
	input  wire logic                  ccb1_wr_i,
	input  wire logic [7:0]            ccb1_wdata_i,
	// channel pins and output flops
	input  wire logic                  switch_pin_a_i,
	input  wire logic                  switch_pin_b_i,
	input  wire logic                  channel_output_flop_a_i,
	input  wire logic                  channel_output_flop_b_i,
	// line answers
	output logic                       presence_en_o,
	output logic                       search_active_o,
	output logic                       search_bit_o,
	output logic                       selected_o,
	// state view
	output logic                       qualified_o,
	output logic                       hidden_o,
	output logic      [1:0]            activity_o,
	output csq_pkg::cond_t             condition_o
);
	import csq_pkg::*;

	qual_state_t r;
	qual_state_t next_r;
	logic [7:0]  default_byte;
	logic [7:0]  active_byte;
	logic        load_now;
	logic        latch_clr;
	cond_t       eff;
	chan_src_t   src_a;
	chan_src_t   src_b;
	logic        qual_now;

	// source value of one channel as chosen by the source select bits
	function automatic logic pick_src(input cond_t c, input chan_src_t s);
		logic v;
		v = 1'b0;
		unique case ({c.source_select_high, c.source_select_low})
			2'b01:   v = s.activity;
			2'b10:   v = s.flop;
			2'b11:   v = s.pin;
			default: v = 1'b0;
		endcase
		return v;
	endfunction : pick_src

	function automatic logic is_hidden(input cond_t c);
		return !(c.source_select_high | c.source_select_low);
	endfunction : is_hidden

	// full qualification for a conditional search
	function automatic logic qualify(input cond_t c, input chan_src_t a,
			input chan_src_t b);
		logic v;
		logic q;
		v = 1'b0;
		q = 1'b0;
		unique case ({c.channel_select_high, c.channel_select_low})
			2'b01:   v = pick_src(c, a);
			2'b10:   v = pick_src(c, b);
			2'b11:   v = pick_src(c, a) | pick_src(c, b);
			default: v = 1'b0;
		endcase
		if (is_hidden(c)) begin
			q = c.match_polarity_bit;
		end else if (!(c.channel_select_high | c.channel_select_low)) begin
			q = !c.match_polarity_bit;
		end else begin
			q = (v == c.match_polarity_bit);
		end
		return q;
	endfunction : qualify

	// latch clear is a write of one into the designated bit
	assign latch_clr = ccb1_wr_i & ccb1_wdata_i[`CSQ_LATCH_CLR_BIT];

	activity_latch_pair u_latch (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.pin_i     ({switch_pin_b_i, switch_pin_a_i}),
		.clear_i   (latch_clr),
		.latch_o   (activity_o)
	);

	// defaults move into the working byte on the first command byte
	assign load_now = cmd_valid_i & !r.loaded;

	condition_store u_store (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.wr_i      (stat_wr_i),
		.addr_i    (stat_addr_i),
		.wdata_i   (stat_wdata_i),
		.load_i    (load_now),
		.default_o (default_byte),
		.active_o  (active_byte)
	);

	// before the first load the default byte is what governs the device
	assign eff = r.loaded ? cond_t'(active_byte) : cond_t'(default_byte);

	// single-channel build ties every channel B source low
	assign src_a = '{activity: activity_o[0], flop: channel_output_flop_a_i,
		pin: switch_pin_a_i};
	assign src_b = TWO_CHANNEL ? chan_src_t'({activity_o[1],
		channel_output_flop_b_i, switch_pin_b_i}) : chan_src_t'(3'h0);

	assign qual_now = qualify(eff, src_a, src_b);

	// rom command flow, search steps and the held qualification
	always_comb begin
		next_r       = r;
		next_r.rdata = 8'h00;
		if (stat_addr_i == `CSQ_ADDR_DEFAULT) begin
			next_r.rdata = default_byte;
		end else if (stat_addr_i == `CSQ_ADDR_ACTIVE) begin
			next_r.rdata = active_byte;
		end
		if (cmd_valid_i) begin
			next_r.loaded           = 1'b1;
			next_r.powerup_presence = 1'b0;
		end
		unique case (r.state)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					next_r.bit_idx = 6'h00;
					next_r.state   = ST_DROPPED;
					if (cmd_byte_i == `CSQ_CMD_MATCH) begin
						next_r.state = ST_MATCH;
					end else if (cmd_byte_i == `CSQ_CMD_COND_SEARCH) begin
						// sampled once, held until the next reset pulse
						next_r.sample    = qual_now;
						next_r.qualified = qual_now;
						if (qual_now) begin
							next_r.state = ST_SRCH_ID;
						end
					end else if (!is_hidden(eff)) begin
						if (cmd_byte_i == `CSQ_CMD_SEARCH) begin
							next_r.state = ST_SRCH_ID;
						end else if (cmd_byte_i == `CSQ_CMD_SKIP) begin
							next_r.state = ST_SELECTED;
						end
					end
				end
			end
			ST_SRCH_ID: begin
				if (slot_rd_i) begin
					next_r.state = ST_SRCH_CMP;
				end
			end
			ST_SRCH_CMP: begin
				if (slot_rd_i) begin
					next_r.state = ST_SRCH_WR;
				end
			end
			ST_SRCH_WR: begin
				if (slot_wr_i) begin
					if (slot_bit_i != rom_id_i[r.bit_idx]) begin
						next_r.state = ST_DROPPED;
					end else if (r.bit_idx == `CSQ_ID_LAST) begin
						next_r.state = ST_SELECTED;
					end else begin
						next_r.bit_idx = r.bit_idx + 6'h01;
						next_r.state   = ST_SRCH_ID;
					end
				end
			end
			ST_MATCH: begin
				if (slot_wr_i) begin
					if (slot_bit_i != rom_id_i[r.bit_idx]) begin
						next_r.state = ST_DROPPED;
					end else if (r.bit_idx == `CSQ_ID_LAST) begin
						next_r.state = ST_SELECTED;
					end else begin
						next_r.bit_idx = r.bit_idx + 6'h01;
					end
				end
			end
			ST_SELECTED: begin
				next_r.state = ST_SELECTED;
			end
			ST_DROPPED: begin
				next_r.state = ST_DROPPED;
			end
		endcase
		// bit to present in the coming read slot: true, then complement
		next_r.search_bit = (next_r.state == ST_SRCH_CMP)
			? !rom_id_i[next_r.bit_idx] : rom_id_i[next_r.bit_idx];
		// a reset pulse ends every pass, whatever was happening
		if (reset_pulse_i) begin
			next_r.state     = ST_IDLE;
			next_r.bit_idx   = 6'h00;
			next_r.qualified = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r                  <= '0;
			r.state            <= ST_IDLE;
			r.powerup_presence <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// presence is withheld in hidden mode except for the power-up one
	assign presence_en_o   = r.powerup_presence | !is_hidden(eff);
	assign search_active_o = (r.state == ST_SRCH_ID) | (r.state == ST_SRCH_CMP);
	assign search_bit_o    = r.search_bit;
	assign selected_o      = (r.state == ST_SELECTED);
	assign qualified_o     = r.qualified;
	assign hidden_o        = is_hidden(eff);
	assign condition_o     = eff;
	assign stat_rdata_o    = r.rdata;

	sequence cond_cmd_s;
		r.state == ST_IDLE && cmd_valid_i && !reset_pulse_i
			&& cmd_byte_i == `CSQ_CMD_COND_SEARCH;
	endsequence

	sequence enter_search_s;
		r.state == ST_SRCH_ID;
	endsequence

	cond_search_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		cond_cmd_s |=> ((r.state == ST_SRCH_ID) == $past(qual_now)))
		else $error("conditional search entry disagrees with condition");

	hidden_pol_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		cond_cmd_s and (is_hidden(eff) && !eff.match_polarity_bit)
		|=> r.state == ST_DROPPED)
		else $error("hidden device joined search with polarity zero");

	no_channel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!is_hidden(eff) && !eff.channel_select_high && !eff.channel_select_low
		|-> qual_now == !eff.match_polarity_bit)
		else $error("no-channel qualification wrong");

	or_channels_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!is_hidden(eff) && eff.channel_select_high && eff.channel_select_low
		&& !eff.match_polarity_bit && (src_a.pin || src_b.pin)
		&& eff.source_select_high && eff.source_select_low |-> !qual_now)
		else $error("or of channels did not block polarity zero");

	held_qual_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!reset_pulse_i && r.state != ST_IDLE |=> $stable(qualified_o))
		else $error("qualification changed during a pass");

	search_step_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.state == ST_SRCH_ID && slot_rd_i && !reset_pulse_i
		|=> search_bit_o == !rom_id_i[r.bit_idx])
		else $error("complement bit not presented");

	full_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.state == ST_SRCH_WR && slot_wr_i && !reset_pulse_i
		&& r.bit_idx == `CSQ_ID_LAST && slot_bit_i == rom_id_i[63]
		|=> selected_o)
		else $error("resolved device not selected");

	hidden_presence_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.loaded && is_hidden(eff) |-> !presence_en_o)
		else $error("presence allowed in hidden mode");

	defaults_load_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!r.loaded && cmd_valid_i && !stat_wr_i
		|=> active_byte == $past(default_byte))
		else $error("defaults not loaded on first command byte");

	single_chan_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!TWO_CHANNEL |-> src_b == 3'h0)
		else $error("channel B source not zero on single channel");

	cond_join_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		cond_cmd_s ##0 qual_now |=> enter_search_s)
		else $error("qualified device did not join the search");

	match_miss_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.state == ST_MATCH && slot_wr_i && !reset_pulse_i
		&& slot_bit_i != rom_id_i[r.bit_idx]
		|=> r.state == ST_DROPPED)
		else $error("mismatching device not dropped");

	pulse_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		reset_pulse_i |=> r.state == ST_IDLE && !qualified_o)
		else $error("reset pulse did not end the pass");

	hidden_search_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		r.state == ST_IDLE && cmd_valid_i && !reset_pulse_i && is_hidden(eff)
		&& cmd_byte_i == `CSQ_CMD_SEARCH |=> r.state == ST_DROPPED)
		else $error("hidden device answered a plain search");

	one_presence_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		cmd_valid_i |=> !r.powerup_presence)
		else $error("power-up presence outlived the first command");

endmodule : conditional_search_qualifier
`default_nettype wire

// ===== tb/csq_line_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "csq_cfg.svh"

// bus master model: issues line events and reads the wired line
module csq_line_master (
	// clock
	input  wire logic       sys_clk_i,
	// device answers
	input  wire logic       search_active_i,
	input  wire logic       search_bit_i,
	// line events
	output logic            reset_pulse_o,
	output logic            cmd_valid_o,
	output logic      [7:0] cmd_byte_o,
	output logic            slot_wr_o,
	output logic            slot_bit_o,
	output logic            slot_rd_o
);
	logic bus_level;

	// open-drain line with pull-up: device only pulls low for a zero
	assign bus_level = !(search_active_i && !search_bit_i);

	initial begin
		reset_pulse_o = 1'b0;
		cmd_valid_o   = 1'b0;
		cmd_byte_o    = 8'h00;
		slot_wr_o     = 1'b0;
		slot_bit_o    = 1'b0;
		slot_rd_o     = 1'b0;
	end

	task line_reset;
		@(posedge sys_clk_i) reset_pulse_o <= 1'b1;
		@(posedge sys_clk_i) reset_pulse_o <= 1'b0;
		#1;
	endtask : line_reset

	// byte qualifier drops after the pulse, so show a changed value
	task send_cmd(input logic [7:0] code);
		@(posedge sys_clk_i) begin
			cmd_valid_o <= 1'b1;
			cmd_byte_o  <= code;
		end
		@(posedge sys_clk_i) begin
			cmd_valid_o <= 1'b0;
			cmd_byte_o  <= ~code;
		end
		#1;
	endtask : send_cmd

	task read_slot(output logic v);
		@(posedge sys_clk_i) slot_rd_o <= 1'b1;
		@(posedge sys_clk_i) slot_rd_o <= 1'b0;
		#1 v = bus_level;
	endtask : read_slot

	task write_slot(input logic b);
		@(posedge sys_clk_i) begin
			slot_wr_o  <= 1'b1;
			slot_bit_o <= b;
		end
		@(posedge sys_clk_i) begin
			slot_wr_o  <= 1'b0;
			slot_bit_o <= ~b;
		end
		#1;
	endtask : write_slot

	// true bit, complement, then chosen bit; 1/1 means nobody answers
	task search(input int flip_at, output logic [63:0] got,
			output logic ok);
		logic t;
		logic c;
		logic dummy;
		ok  = 1'b1;
		got = 64'h0;
		for (int i = 0; i < `CSQ_ID_BITS && ok; i++) begin
			t = bus_level;
			read_slot(c);
			read_slot(dummy);
			if (t == c) begin
				ok = 1'b0;
			end else begin
				got[i] = t;
				write_slot((i == flip_at) ? ~t : t);
			end
		end
	endtask : search

	// match sends the identifier bit 0 first
	task match(input logic [63:0] id);
		send_cmd(`CSQ_CMD_MATCH);
		for (int i = 0; i < `CSQ_ID_BITS; i++) begin
			write_slot(id[i]);
		end
	endtask : match
endmodule : csq_line_master
`default_nettype wire

// ===== tb/tb_conditional_search_qualifier.sv
`timescale 1ns/1ns
`default_nettype none
`include "csq_cfg.svh"

module tb_conditional_search_qualifier;
	import csq_pkg::*;

	// condition byte, pins, flops, latch activity, expected result
	typedef struct packed {
		logic [7:0] cond;
		logic       pa, pb, fa, fb, aa, ab, exp;
	} row_t;

	logic sys_clk_i, rstn_i, search_active_o, search_bit_o, selected_o;
	logic reset_pulse_i, cmd_valid_i, slot_wr_i, slot_bit_i, slot_rd_i;
	logic stat_wr_i, ccb1_wr_i, presence_en_o, qualified_o, hidden_o;
	logic pin_a, pin_b, flop_a, flop_b, ok, qual_one;
	logic [7:0] cmd_byte_i, stat_wdata_i, stat_rdata_o, ccb1_wdata_i, d;
	logic [2:0] stat_addr_i;
	logic [1:0] activity_o;
	logic [63:0] rom_id, got;
	cond_t condition_o;
	row_t rows [17];
	int errors = 0;
	int checked = 0;
	int cycles = 0;

	// clock: 100 MHz
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	conditional_search_qualifier dut (.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i), .reset_pulse_i(reset_pulse_i),
		.cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
		.slot_wr_i(slot_wr_i), .slot_bit_i(slot_bit_i),
		.slot_rd_i(slot_rd_i), .rom_id_i(rom_id), .stat_wr_i(stat_wr_i),
		.stat_addr_i(stat_addr_i), .stat_wdata_i(stat_wdata_i),
		.stat_rdata_o(stat_rdata_o), .ccb1_wr_i(ccb1_wr_i),
		.ccb1_wdata_i(ccb1_wdata_i), .switch_pin_a_i(pin_a),
		.switch_pin_b_i(pin_b), .channel_output_flop_a_i(flop_a),
		.channel_output_flop_b_i(flop_b), .presence_en_o(presence_en_o),
		.search_active_o(search_active_o), .search_bit_o(search_bit_o),
		.selected_o(selected_o), .qualified_o(qualified_o),
		.hidden_o(hidden_o), .activity_o(activity_o),
		.condition_o(condition_o));

	// single-channel build on the same inputs: channel B must read zero
	conditional_search_qualifier #(.TWO_CHANNEL(1'b0)) dut_one (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.reset_pulse_i(reset_pulse_i), .cmd_valid_i(cmd_valid_i),
		.cmd_byte_i(cmd_byte_i), .slot_wr_i(slot_wr_i),
		.slot_bit_i(slot_bit_i), .slot_rd_i(slot_rd_i), .rom_id_i(rom_id),
		.stat_wr_i(stat_wr_i), .stat_addr_i(stat_addr_i),
		.stat_wdata_i(stat_wdata_i), .stat_rdata_o(), .ccb1_wr_i(ccb1_wr_i),
		.ccb1_wdata_i(ccb1_wdata_i), .switch_pin_a_i(pin_a),
		.switch_pin_b_i(pin_b), .channel_output_flop_a_i(flop_a),
		.channel_output_flop_b_i(flop_b), .presence_en_o(),
		.search_active_o(), .search_bit_o(), .selected_o(),
		.qualified_o(qual_one), .hidden_o(), .activity_o(),
		.condition_o());

	csq_line_master m (.sys_clk_i(sys_clk_i),
		.search_active_i(search_active_o), .search_bit_i(search_bit_o),
		.reset_pulse_o(reset_pulse_i), .cmd_valid_o(cmd_valid_i),
		.cmd_byte_o(cmd_byte_i), .slot_wr_o(slot_wr_i),
		.slot_bit_o(slot_bit_i), .slot_rd_o(slot_rd_i));

	task complete_run;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task check(input logic [63:0] seen, input logic [63:0] exp,
			input string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask : check

	// cut a hang short; the whole run needs well under this
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			complete_run();
		end
	end

	task stat_write(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk_i) begin
			stat_wr_i    <= 1'b1;
			stat_addr_i  <= a;
			stat_wdata_i <= v;
		end
		@(posedge sys_clk_i) stat_wr_i <= 1'b0;
		#1;
	endtask : stat_write

	// read data is registered one cycle after the address
	task stat_read(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk_i) stat_addr_i <= a;
		@(posedge sys_clk_i);
		#1 v = stat_rdata_o;
	endtask : stat_read

	task power_on;
		@(posedge sys_clk_i) rstn_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		#1;
	endtask : power_on

	task run_row(input row_t r);
		@(posedge sys_clk_i) begin
			pin_a  <= r.pa;
			pin_b  <= r.pb;
			flop_a <= r.fa;
			flop_b <= r.fb;
		end
		repeat (2) @(posedge sys_clk_i);
		ccb1_wr_i    <= 1'b1;
		ccb1_wdata_i <= 8'h80;
		@(posedge sys_clk_i) ccb1_wr_i <= 1'b0;
		@(posedge sys_clk_i);
		#1 check(activity_o, 2'b00, "latch clear");
		// toggle away and back so the level is kept but an edge is seen
		if (r.aa) begin
			@(posedge sys_clk_i) pin_a <= ~r.pa;
			@(posedge sys_clk_i) pin_a <= r.pa;
		end
		if (r.ab) begin
			@(posedge sys_clk_i) pin_b <= ~r.pb;
			@(posedge sys_clk_i) pin_b <= r.pb;
		end
		repeat (2) @(posedge sys_clk_i);
		#1 check(activity_o, {r.ab, r.aa}, "latch");
		stat_write(`CSQ_ADDR_ACTIVE, r.cond);
		stat_read(`CSQ_ADDR_ACTIVE, d);
		check(d, r.cond, "active byte");
		m.line_reset();
		m.send_cmd(`CSQ_CMD_COND_SEARCH);
		check(qualified_o, r.exp, "qualify");
		check(search_active_o, r.exp, "joins search");
		if (r.exp) begin
			m.search(-1, got, ok);
			check(got, rom_id, "resolved id");
			check(selected_o, 1'b1, "selected");
		end
	endtask : run_row

	initial begin
		rstn_i = 1'b0;
		stat_wr_i = 1'b0;
		stat_addr_i = 3'h0;
		stat_wdata_i = 8'h00;
		ccb1_wr_i = 1'b0;
		ccb1_wdata_i = 8'h00;
		{pin_a, pin_b, flop_a, flop_b} = 4'hF;
		rom_id = 64'h5A3C_96E1_0F7B_24D8; // arbitrary identifier
		rows = '{{8'h0F, 7'b1011001}, {8'h0E, 7'b1011000},
			{8'h0C, 7'b0001001}, {8'h0D, 7'b0001000},
			{8'h0B, 7'b0011101}, {8'h0A, 7'b0011100},
			{8'h17, 7'b0111001}, {8'h17, 7'b1011000},
			{8'h14, 7'b0010001}, {8'h13, 7'b0011011},
			{8'h1E, 7'b0111000}, {8'h1E, 7'b0011001},
			{8'h1F, 7'b0111001}, {8'h06, 7'b1111001},
			{8'h07, 7'b1111000}, {8'h01, 7'b0011001},
			{8'h00, 7'b0011000}};
		power_on();
		check(condition_o, `CSQ_COND_RESET, "reset cond");
		m.line_reset();
		m.send_cmd(`CSQ_CMD_SKIP);
		foreach (rows[i]) run_row(rows[i]);
		// hidden mode: silent after resets, ignores search, takes match
		check(presence_en_o, 1'b0, "hidden presence");
		m.line_reset();
		m.send_cmd(`CSQ_CMD_SEARCH);
		check(search_active_o, 1'b0, "hidden search");
		m.line_reset();
		m.match(rom_id);
		check(selected_o, 1'b1, "hidden match");
		stat_write(`CSQ_ADDR_ACTIVE, 8'h0F);
		check(hidden_o, 1'b0, "hidden left");
		// result frozen for the pass although the pin moves
		@(posedge sys_clk_i) pin_a <= 1'b1;
		m.line_reset();
		m.send_cmd(`CSQ_CMD_COND_SEARCH);
		@(posedge sys_clk_i) pin_a <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1 check(qualified_o, 1'b1, "held result");
		m.search(5, got, ok);
		check(selected_o, 1'b0, "dropped on miss");
		check(search_active_o, 1'b0, "stays out");
		m.line_reset();
		m.match(rom_id ^ 64'h1);
		check(selected_o, 1'b0, "wrong match");
		check(condition_o, 8'h0F, "kept cond");
		// no channel with polarity one still answers a plain search
		stat_write(`CSQ_ADDR_ACTIVE, 8'h07);
		m.line_reset();
		m.send_cmd(`CSQ_CMD_SEARCH);
		check(search_active_o, 1'b1, "plain search");
		// channel B pin high: only the two-channel build may see it
		@(posedge sys_clk_i) pin_b <= 1'b1;
		stat_write(`CSQ_ADDR_ACTIVE, 8'h17);
		m.line_reset();
		m.send_cmd(`CSQ_CMD_COND_SEARCH);
		check(qualified_o, 1'b1, "two channel B");
		check(qual_one, 1'b0, "one channel B");
		// power up again with a hidden default programmed
		power_on();
		check(activity_o, 2'b00, "latch power-up");
		stat_write(`CSQ_ADDR_DEFAULT, 8'hF9);
		stat_write(`CSQ_ADDR_DEFAULT, 8'hFF);
		stat_read(`CSQ_ADDR_DEFAULT, d);
		check(d, 8'hF9, "one-time default");
		check(presence_en_o, 1'b1, "power-up presence");
		m.line_reset();
		m.send_cmd(8'h00);
		stat_read(`CSQ_ADDR_ACTIVE, d);
		check(d, 8'hF9, "default loaded");
		m.line_reset();
		check(presence_en_o, 1'b0, "no second presence");
		complete_run();
	end
endmodule : tb_conditional_search_qualifier
`default_nettype wire
